// File: rtl/cgu_params.svh
// offsets, field positions, reset values and frequency figures of the clock generation unit
`ifndef CGU_PARAMS_SVH
`define CGU_PARAMS_SVH

// ****************************************
// counts
// ****************************************
`define NUM_CFG 16
`define NUM_GEN 17
`define NUM_FAST 4

// ****************************************
// register byte offsets
// ****************************************
`define OFS_PLL_CTRL 8'h00
`define OFS_PLL_FREQ 8'h04
`define OFS_NET_GATE 8'h08
`define OFS_MON_SEL 8'h0C
`define OFS_CLK_LEVEL 8'h10
`define OFS_PARKED 8'h14
`define OFS_CFG_BASE 8'h40

// ****************************************
// field positions
// ****************************************
`define PLL_MULT_LSB 0
`define PLL_DIV_LSB 8
`define PLL_OD_LSB 16
`define PLL_INSEL_BIT 20
`define PLL_BYPASS_BIT 24
`define CFG_SRC_LSB 0
`define CFG_PRESC_LSB 4
`define CFG_EN_BIT 8

// ****************************************
// source codes and reset values
// ****************************************
`define SRC_PLL 2'h0
`define SRC_RC 2'h1
`define SRC_EXT 2'h2
`define SRC_LSE 2'h3
`define RST_MULT 6'h01
`define RST_DIV 6'h01
`define RST_OD 2'h0
`define RST_MON_SEL 5'h00

// ****************************************
// frequencies in kHz, crystal in Hz
// ****************************************
`define RC_OSC_KHZ 8000
`define EXT_MIN_KHZ 8000
`define EXT_MAX_KHZ 24000
`define LSE_HZ 32768

`endif

// File: rtl/cgu_pkg.sv
// types shared by the clock generation unit
`include "cgu_params.svh"

package cgu_pkg;

    // pll control fields driven to the analog pll macro
    typedef struct packed {
        logic bypass;
        logic in_sel;
        logic [1:0] out_div;
        logic [5:0] div;
        logic [5:0] mult;
    } pll_ctrl_t;

    // settings of one generated clock
    typedef struct packed {
        logic [1:0] src;
        logic [2:0] presc;
        logic en;
    } gen_cfg_t;

    // running state of one generated clock
    typedef struct packed {
        gen_cfg_t act;
        logic [6:0] cnt;
        logic park;
        logic out;
    } gen_state_t;

    // captured ahb address phase
    typedef struct packed {
        logic pend;
        logic wr;
        logic [7:0] addr;
    } bus_phase_t;

    // whole state of the unit
    typedef struct packed {
        pll_ctrl_t pll;
        logic [1:0] net_en;
        logic [4:0] mon_sel;
        gen_cfg_t [`NUM_CFG-1:0] cfg;
        gen_state_t [`NUM_GEN-1:0] gen;
        logic [3:0] lvl_prev;
        logic [1:0] net_gate;
        logic [1:0] net_out;
        logic mon_out;
        logic pll_ref;
        bus_phase_t bus;
        logic [31:0] rdata;
    } cgu_state_t;

endpackage

// File: rtl/clock_gen_unit.sv
// clock generation unit: source muxing, pll control, prescalers, gating, monitor
//
// Notes on behaviour
// RQ1: system clock from external or rc oscillator
// RQ2: low-speed crystal is an extra source
// RQ3: pll input is external or rc clock
// RQ4: pll input mux chosen by register bit
// RQ5: pll frequency is fin times m over n over od
// RQ6: output divider gives 1, 2, 4 or 8
// RQ7: pll frequency derived from software fields
// RQ8: separate clocks for every peripheral group
// RQ9: each clock has its own source select
// RQ10: fast clocks divide by 1 to 8
// RQ11: slow clocks divide by 1 to 128
// RQ12: random clock only from pll, undivided
// RQ13: converter and random clocks stop in sleep
// RQ14: network pad clocks gated by register
// RQ15: any generated clock selectable for monitoring
// RQ16: pll bypass passes pll input straight out
// RQ17: setting changes never truncate clock phases; monitor select, pll input select and bypass changes take effect at once
//
// The AHB-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`include "cgu_params.svh"

module clock_gen_unit #(
    parameter int EXT_OSC_KHZ = `EXT_MIN_KHZ
) (
    input wire logic ref_clk, // 50 MHz block clock
    input wire logic reset_n, // asynchronous reset, active low
    input wire logic hsel, // ahb slave select
    input wire logic [31:0] haddr, // ahb address
    input wire logic [1:0] htrans, // ahb transfer type
    input wire logic hwrite, // ahb write
    input wire logic [2:0] hsize, // ahb size, words only
    input wire logic [31:0] hwdata, // ahb write data
    input wire logic hready, // ahb bus ready
    output logic hreadyout, // ahb slave ready
    output logic hresp, // ahb response, always okay
    output logic [31:0] hrdata, // ahb read data
    input wire logic ext_osc_clk, // external oscillator level
    input wire logic rc_osc_clk, // internal rc oscillator level
    input wire logic lse_clk, // 32.768 kHz crystal level
    input wire logic pll_clk, // analog pll output level
    input wire logic sleep_req, // cpu is in sleep mode
    input wire logic net_rx_pad_clk, // network receive clock pad
    input wire logic net_tx_pad_clk, // network transmit clock pad
    output cgu_pkg::pll_ctrl_t pll_cfg, // fields to the pll macro
    output logic pll_ref_clk, // selected pll input
    output logic system_clk, // system clock
    output logic converter_clk, // converter clock
    output logic sync_serial_clk, // synchronous serial clock
    output logic uart_kernel_clk, // uart clock
    output logic timer0_clk, // first timer clock
    output logic timer1_clk, // second timer clock
    output logic [7:0] pwm_clk, // pwm channel clocks
    output logic rtc_kernel_clk, // real time clock
    output logic watchdog_clk, // watchdog clock
    output logic random_gen_clk, // random generator clock
    output logic net_rx_clk, // gated network receive clock
    output logic net_tx_clk, // gated network transmit clock
    output logic clk_monitor // monitored clock
);

    // ****************************************
    // elaboration check
    // ****************************************
    if (EXT_OSC_KHZ < `EXT_MIN_KHZ || EXT_OSC_KHZ > `EXT_MAX_KHZ) begin : g_bad_ext
        $error("external oscillator frequency outside 8 to 24 MHz");
    end

    // ****************************************
    // helpers
    // ****************************************

    // one step of a generated clock; changes land only in a low phase
    function automatic cgu_pkg::gen_state_t gen_step(input cgu_pkg::gen_state_t s,
        input cgu_pkg::gen_cfg_t want, input logic [3:0] lvl,
        input logic [3:0] rise, input logic [3:0] fall);
        cgu_pkg::gen_state_t n;
        logic [6:0] mask;
        logic [6:0] sh;
        n = s;
        sh = 7'h00;
        mask = 7'((8'h01 << s.act.presc) - 8'h01);
        if (s.park) begin
            // held low; restart at a falling edge of the new source
            n.act = want;
            n.out = 1'b0;
            if (want.en && fall[want.src]) begin
                n.park = 1'b0;
                n.cnt = 7'h00;
            end
        end else begin
            if (rise[s.act.src]) begin
                n.cnt = s.cnt + 7'h01;
            end
            // RQ17: switch at end of phase
            if (want != s.act && fall[s.act.src] && (s.cnt & mask) == 7'h00) begin
                n.park = 1'b1;
                n.act = want;
                n.cnt = 7'h00;
                n.out = 1'b0;
            end else if (s.act.presc == 3'h0) begin
                n.out = lvl[s.act.src];
            end else begin
                sh = n.cnt >> (s.act.presc - 3'h1);
                n.out = sh[0];
            end
        end
        return n;
    endfunction

    // pll output frequency in kHz
    function automatic logic [31:0] pll_khz(input logic [31:0] pll_in_freq,
        input cgu_pkg::pll_ctrl_t p);
        logic [31:0] prod;
        prod = pll_in_freq * {26'h000_0000, p.mult};
        if (p.bypass) begin
            return pll_in_freq;
        end
        if (p.div == 6'h00) begin
            return 32'h0000_0000;
        end
        return (prod / {26'h000_0000, p.div}) >> {p.out_div[1], p.out_div[0]};
    endfunction

    // ****************************************
    // state
    // ****************************************
    cgu_pkg::cgu_state_t st_q;
    cgu_pkg::cgu_state_t st_d;
    logic pll_ref_lvl;
    logic pll_out_lvl;
    logic [3:0] lvl;
    logic [3:0] rise;
    logic [3:0] fall;
    logic [31:0] fin_khz;
    logic [31:0] freq_khz;
    logic [`NUM_GEN-1:0] gen_out;
    logic [`NUM_GEN-1:0] gen_park;
    logic [20:0] mon_vec;

    // RQ3: pll input mux
    assign pll_ref_lvl = st_q.pll.in_sel ? ext_osc_clk : rc_osc_clk;
    // RQ16: bypass skips the pll
    assign pll_out_lvl = st_q.pll.bypass ? pll_ref_lvl : pll_clk;
    // RQ2: crystal is source code three
    assign lvl = {lse_clk, ext_osc_clk, rc_osc_clk, pll_out_lvl};
    assign rise = lvl & ~st_q.lvl_prev;
    assign fall = ~lvl & st_q.lvl_prev;
    // RQ7: frequency from software fields
    assign fin_khz = st_q.pll.in_sel ? 32'(EXT_OSC_KHZ) : 32'(`RC_OSC_KHZ);
    assign freq_khz = pll_khz(fin_khz, st_q.pll);

    // flatten generated clock state for status and monitor
    always_comb begin
        for (int i = 0; i < `NUM_GEN; i++) begin
            gen_out[i] = st_q.gen[i].out;
            gen_park[i] = st_q.gen[i].park;
        end
    end
    assign mon_vec = {st_q.pll_ref, pll_out_lvl, st_q.net_out, gen_out};

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        cgu_pkg::gen_cfg_t want;
        logic [3:0] idx;
        st_d = st_q;
        want = '0;
        idx = 4'h0;
        st_d.lvl_prev = lvl;
        st_d.pll_ref = pll_ref_lvl;

        // data phase write
        if (st_q.bus.pend && st_q.bus.wr) begin
            idx = st_q.bus.addr[5:2];
            case (st_q.bus.addr)
                `OFS_PLL_CTRL: begin
                    // RQ5: six-bit m and n
                    st_d.pll.mult = hwdata[`PLL_MULT_LSB +: 6];
                    st_d.pll.div = hwdata[`PLL_DIV_LSB +: 6];
                    // RQ6: two-bit output divider
                    st_d.pll.out_div = hwdata[`PLL_OD_LSB +: 2];
                    // RQ4: input select bit
                    st_d.pll.in_sel = hwdata[`PLL_INSEL_BIT];
                    st_d.pll.bypass = hwdata[`PLL_BYPASS_BIT];
                end
                `OFS_NET_GATE: st_d.net_en = hwdata[1:0];
                `OFS_MON_SEL: st_d.mon_sel = hwdata[4:0];
                default: begin
                    if (st_q.bus.addr[7:6] == 2'h1) begin
                        // RQ9: per-clock source select
                        st_d.cfg[idx].src = hwdata[`CFG_SRC_LSB +: 2];
                        st_d.cfg[idx].en = hwdata[`CFG_EN_BIT];
                        // RQ10: fast clocks limited to 1/8
                        if (idx < 4'(`NUM_FAST)) begin
                            st_d.cfg[idx].presc = {1'b0, hwdata[`CFG_PRESC_LSB +: 2]};
                        end else begin
                            // RQ11: slow clocks up to 1/128
                            st_d.cfg[idx].presc = hwdata[`CFG_PRESC_LSB +: 3];
                        end
                    end
                end
            endcase
        end

        // RQ8: one divider per generated clock
        for (int i = 0; i < `NUM_CFG; i++) begin
            want = st_q.cfg[i];
            // RQ13: converter stops in sleep
            if (i == 1) begin
                want.en = st_q.cfg[i].en & ~sleep_req;
            end
            st_d.gen[i] = gen_step(st_q.gen[i], want, lvl, rise, fall);
        end
        // RQ12: random clock fixed to pll, undivided
        want.src = `SRC_PLL;
        want.presc = 3'h0;
        // RQ13: random clock stops in sleep
        want.en = ~sleep_req;
        st_d.gen[`NUM_GEN-1] = gen_step(st_q.gen[`NUM_GEN-1], want, lvl, rise, fall);

        // RQ14: gate changes only while the pad is low
        if (!net_rx_pad_clk) begin
            st_d.net_gate[0] = st_q.net_en[0];
        end
        if (!net_tx_pad_clk) begin
            st_d.net_gate[1] = st_q.net_en[1];
        end
        st_d.net_out = {net_tx_pad_clk & st_d.net_gate[1], net_rx_pad_clk & st_d.net_gate[0]};

        // RQ15: monitor any clock
        st_d.mon_out = (st_q.mon_sel < 5'd21) ? mon_vec[st_q.mon_sel] : 1'b0;

        // address phase capture, read data from the updated registers
        st_d.bus.pend = hsel && htrans[1] && hready;
        st_d.bus.wr = hwrite;
        st_d.bus.addr = {haddr[7:2], 2'b00};
        st_d.rdata = 32'h0000_0000;
        if (st_d.bus.pend && !hwrite) begin
            idx = haddr[5:2];
            case (st_d.bus.addr)
                `OFS_PLL_CTRL: begin
                    st_d.rdata[`PLL_MULT_LSB +: 6] = st_d.pll.mult;
                    st_d.rdata[`PLL_DIV_LSB +: 6] = st_d.pll.div;
                    st_d.rdata[`PLL_OD_LSB +: 2] = st_d.pll.out_div;
                    st_d.rdata[`PLL_INSEL_BIT] = st_d.pll.in_sel;
                    st_d.rdata[`PLL_BYPASS_BIT] = st_d.pll.bypass;
                end
                `OFS_PLL_FREQ: st_d.rdata = pll_khz(fin_khz, st_d.pll);
                `OFS_NET_GATE: st_d.rdata[1:0] = st_d.net_en;
                `OFS_MON_SEL: st_d.rdata[4:0] = st_d.mon_sel;
                `OFS_CLK_LEVEL: st_d.rdata[18:0] = {st_q.net_out, gen_out};
                `OFS_PARKED: st_d.rdata[`NUM_GEN-1:0] = gen_park;
                default: begin
                    if (haddr[7:6] == 2'h1) begin
                        st_d.rdata[`CFG_SRC_LSB +: 2] = st_d.cfg[idx].src;
                        st_d.rdata[`CFG_PRESC_LSB +: 3] = st_d.cfg[idx].presc;
                        st_d.rdata[`CFG_EN_BIT] = st_d.cfg[idx].en;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= '0;
            st_q.pll.mult <= `RST_MULT;
            st_q.pll.div <= `RST_DIV;
            st_q.pll.out_div <= `RST_OD;
            st_q.mon_sel <= `RST_MON_SEL;
            for (int i = 0; i < `NUM_CFG; i++) begin
                // RQ1: each of the 16 configurable clocks starts from the rc oscillator; the random clock starts from the pll
                st_q.cfg[i] <= '{src: `SRC_RC, presc: 3'h0, en: 1'b1};
                st_q.gen[i].act <= '{src: `SRC_RC, presc: 3'h0, en: 1'b1};
                st_q.gen[i].park <= 1'b1;
            end
            st_q.gen[`NUM_GEN-1].act <= '{src: `SRC_PLL, presc: 3'h0, en: 1'b1};
            st_q.gen[`NUM_GEN-1].park <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st_q.rdata;
    assign pll_cfg = st_q.pll;
    assign pll_ref_clk = st_q.pll_ref;
    assign system_clk = gen_out[0];
    assign converter_clk = gen_out[1];
    assign sync_serial_clk = gen_out[2];
    assign uart_kernel_clk = gen_out[3];
    assign timer0_clk = gen_out[4];
    assign timer1_clk = gen_out[5];
    assign pwm_clk = gen_out[13:6];
    assign rtc_kernel_clk = gen_out[14];
    assign watchdog_clk = gen_out[15];
    assign random_gen_clk = gen_out[16];
    assign net_rx_clk = st_q.net_out[0];
    assign net_tx_clk = st_q.net_out[1];
    assign clk_monitor = st_q.mon_out;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    property p_sleep_gate;
        sleep_req && !st_q.gen[1].park ##1 !st_q.gen[1].act.en |-> !converter_clk;
    endproperty
    a_sleep_gate: assert property (p_sleep_gate) else $error("converter clock high in sleep"); // RQ13

    property p_rng_src;
        st_q.gen[16].act.src == `SRC_PLL && st_q.gen[16].act.presc == 3'h0;
    endproperty
    a_rng_src: assert property (p_rng_src) else $error("random clock left the pll"); // RQ12

    property p_fast_presc;
        st_q.cfg[0].presc[2] == 1'b0 && st_q.cfg[3].presc[2] == 1'b0;
    endproperty
    a_fast_presc: assert property (p_fast_presc) else $error("fast prescaler above 1/8"); // RQ10

    property p_switch_low;
        $changed(st_q.gen[0].act) |-> !system_clk && st_q.gen[0].park;
    endproperty
    a_switch_low: assert property (p_switch_low) else $error("system clock switched high"); // RQ17

    property p_net_gate;
        net_rx_clk |-> $past(net_rx_pad_clk) && st_q.net_gate[0];
    endproperty
    a_net_gate: assert property (p_net_gate) else $error("receive clock passed while gated"); // RQ14

    property p_monitor;
        st_q.mon_sel == 5'd0 && $stable(st_q.mon_sel) |=> clk_monitor == $past(system_clk);
    endproperty
    a_monitor: assert property (p_monitor) else $error("monitor does not follow"); // RQ15

    property p_freq;
        !st_q.pll.bypass && st_q.pll.mult == 6'd6 && st_q.pll.div == 6'd2
            && st_q.pll.out_div == 2'd1 |-> freq_khz == fin_khz * 32'd3 / 32'd2;
    endproperty
    a_freq: assert property (p_freq) else $error("pll frequency wrong"); // RQ5

    property p_slow_write;
        st_q.bus.pend && st_q.bus.wr && st_q.bus.addr == 8'h50
            |=> st_q.cfg[4].presc == $past(hwdata[6:4]);
    endproperty
    a_slow_write: assert property (p_slow_write) else $error("timer prescaler not taken"); // RQ11

    c_park_exit: cover property (st_q.gen[0].park ##1 !st_q.gen[0].park);
    c_sleep: cover property (sleep_req ##[1:300] st_q.gen[1].park);
    c_bus_write: cover property (st_q.bus.pend && st_q.bus.wr);

endmodule

// File: dv/src_model.sv
// free-running source oscillators and network pad clocks seen by the unit
`timescale 1ns/1ns

module src_model #(
    parameter int EXT_HALF = 2, // external half period in block cycles
    parameter int RC_HALF = 3, // rc half period
    parameter int LSE_HALF = 5, // crystal stand-in half period
    parameter int PLL_HALF = 4, // pll output half period
    parameter int RX_HALF = 3, // receive pad half period
    parameter int TX_HALF = 4 // transmit pad half period
) (
    input wire logic ref_clk, // block clock
    input wire logic reset_n, // active low reset
    output logic [5:0] lvl_q // ext, rc, lse, pll, rx, tx levels
);
    localparam int HALF [6] = '{EXT_HALF, RC_HALF, LSE_HALF, PLL_HALF, RX_HALF, TX_HALF};
    int cnt_q [6];

    // each level flips after its half period; oscillators never stop
    // external near 12.5 MHz, rc near 8 MHz
    // slow crystal stand-in on its own level
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            lvl_q <= 6'h00;
            for (int i = 0; i < 6; i++) begin
                cnt_q[i] <= 0;
            end
        end else begin
            for (int i = 0; i < 6; i++) begin
                if (cnt_q[i] == HALF[i] - 1) begin
                    cnt_q[i] <= 0;
                    lvl_q[i] <= ~lvl_q[i];
                end else begin
                    cnt_q[i] <= cnt_q[i] + 1;
                end
            end
        end
    end
endmodule

// File: dv/clock_gen_unit_tb_top.sv
// self-checking bench for the clock generation unit
`timescale 1ns/1ns
`include "cgu_params.svh"

module clock_gen_unit_tb_top;
    localparam int WIN = 1024; // cycles per rate measurement
    localparam int SETTLE = 600; // cycles allowed for a clean switch
    localparam int LIMIT = 80000; // cycle ceiling for the whole run
    // periods: pll, rc, ext, crystal, rx pad, tx pad
    localparam int PER [6] = '{8, 6, 4, 10, 6, 8};
    logic ref_clk = 1'b0;
    logic reset_n; // starts unknown so the first low level is a real falling edge
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic sleep_req = 1'b0;
    logic hready, hreadyout, hresp, clk_monitor, system_clk;
    logic [31:0] hrdata;
    logic [5:0] lvl;
    cgu_pkg::pll_ctrl_t pll_cfg;
    logic last_sys = 1'b0;
    int phase_len = 0;
    int cycles = 0;
    int failures = 0;
    int num_checks = 0;

    assign hready = hreadyout;

    src_model src_model_i (.ref_clk(ref_clk), .reset_n(reset_n), .lvl_q(lvl));

    clock_gen_unit #(.EXT_OSC_KHZ(12000)) clock_gen_unit_i (
        .ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .ext_osc_clk(lvl[0]), .rc_osc_clk(lvl[1]), .lse_clk(lvl[2]), .pll_clk(lvl[3]),
        .sleep_req(sleep_req), .net_rx_pad_clk(lvl[4]), .net_tx_pad_clk(lvl[5]),
        .pll_cfg(pll_cfg), .pll_ref_clk(), .system_clk(system_clk), .converter_clk(),
        .sync_serial_clk(), .uart_kernel_clk(), .timer0_clk(), .timer1_clk(),
        .pwm_clk(), .rtc_kernel_clk(), .watchdog_clk(), .random_gen_clk(),
        .net_rx_clk(), .net_tx_clk(), .clk_monitor(clk_monitor)
    );

    // ****
    // clock, ceiling and phase watch
    // ****
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    // a hang counts as a mismatch
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            failures++;
            summarize();
        end
    end

    always @(posedge ref_clk) begin
        if (reset_n !== 1'b1) begin
            phase_len = 1;
        end else if (system_clk === last_sys) begin
            phase_len++;
        end else begin
            num_checks++;
            if (phase_len < 2) begin
                failures++;
                $display("ERROR system phase expected 2 seen %0d", phase_len);
            end
            phase_len = 1;
        end
        last_sys = system_clk;
    end

    // ****
    // shared tasks
    // ****
    task automatic summarize();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wait_rdy();
        do @(posedge ref_clk); while (hready !== 1'b1);
    endtask

    // one single word transfer, address phase then data phase
    task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, ofs};
        hwrite <= wr;
        htrans <= 2'h2;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
        check("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
    endtask

    task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, ofs, d, x);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] ofs, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, ofs, 32'h0000_0000, x);
        check(what, exp, x);
    endtask

    function automatic logic [31:0] pll_word(int m, int n, int od, int sel, int byp);
        return 32'(m) | (32'(n) << 8) | (32'(od) << 16) | (32'(sel) << 20) | (32'(byp) << 24);
    endfunction

    // count monitor rises over a window; period 0 means stopped
    task automatic rate(input logic [4:0] mon, input int period);
        int rises;
        int exp;
        logic prev;
        rises = 0;
        exp = (period == 0) ? 0 : WIN / period;
        wr(`OFS_MON_SEL, {27'h000_0000, mon});
        repeat (SETTLE) @(posedge ref_clk);
        prev = clk_monitor;
        repeat (WIN) begin
            @(posedge ref_clk);
            if (clk_monitor === 1'b1 && prev === 1'b0) rises++;
            prev = clk_monitor;
        end
        num_checks++;
        if (rises < exp - 1 || rises > exp + 1 || (period == 0 && rises != 0)) begin
            failures++;
            $display("ERROR monitor %0d rises expected %0d seen %0d", mon, exp, rises);
        end
    endtask

    // ****
    // scenarios
    // ****
    task automatic t_reset();
        rd_chk("pll_ctrl", `OFS_PLL_CTRL, 32'h0000_0101);
        check("pll_cfg", 32'h0000_0041, {16'h0000, pll_cfg});
        rd_chk("pll_freq", `OFS_PLL_FREQ, 32'h0000_1f40);
        rd_chk("clk_cfg0", `OFS_CFG_BASE, 32'h0000_0101);
        rd_chk("net_gate", `OFS_NET_GATE, 32'h0000_0000);
        rd_chk("unmapped", 8'h30, 32'h0000_0000);
    endtask

    task automatic t_pll_freq();
        for (int od = 0; od < 4; od++) begin
            wr(`OFS_PLL_CTRL, pll_word(6, 2, od, 0, 0));
            rd_chk("pll_freq od", `OFS_PLL_FREQ, 32'h0000_5dc0 >> od);
        end
        check("pll_cfg od", 32'h0000_0003, {30'h0000_0000, pll_cfg.out_div});
        wr(`OFS_PLL_CTRL, pll_word(2, 3, 0, 1, 0));
        rd_chk("pll_freq ext", `OFS_PLL_FREQ, 32'h0000_1f40);
        wr(`OFS_PLL_CTRL, pll_word(2, 3, 0, 1, 1));
        rd_chk("pll_freq bypass", `OFS_PLL_FREQ, 32'h0000_2ee0);
        wr(`OFS_PLL_CTRL, pll_word(6, 0, 0, 0, 0));
        rd_chk("pll_freq div0", `OFS_PLL_FREQ, 32'h0000_0000);
        rd_chk("pll_ctrl", `OFS_PLL_CTRL, 32'h0000_0006);
    endtask

    task automatic t_src();
        for (int s = 0; s < 3; s++) begin
            wr(`OFS_CFG_BASE, 32'h0000_0100 | 32'(s));
            rate(5'h00, PER[s]);
        end
        wr(`OFS_CFG_BASE + 8'h38, 32'h0000_0103);
        rate(5'h0e, PER[3]);
    endtask

    task automatic t_presc();
        for (int n = 0; n < 8; n++) begin
            wr(`OFS_CFG_BASE + 8'h10, 32'h0000_0102 | (32'(n) << 4));
            rate(5'h04, PER[2] << n);
        end
        rate(5'h05, PER[1]);
        wr(`OFS_CFG_BASE + 8'h0c, 32'h0000_0172);
        rd_chk("uart cfg", `OFS_CFG_BASE + 8'h0c, 32'h0000_0132);
        rate(5'h03, PER[2] * 8);
    endtask

    task automatic t_sleep();
        sleep_req <= 1'b1;
        rate(5'h01, 0);
        rate(5'h10, 0);
        rate(5'h00, PER[2]);
        sleep_req <= 1'b0;
        rate(5'h10, PER[0]);
        rate(5'h01, PER[1]);
    endtask

    task automatic t_net();
        rate(5'h11, 0);
        wr(`OFS_NET_GATE, 32'h0000_0003);
        rate(5'h11, PER[4]);
        rate(5'h12, PER[5]);
        wr(`OFS_NET_GATE, 32'h0000_0001);
        rate(5'h12, 0);
    endtask

    task automatic t_pll_mon();
        wr(`OFS_PLL_CTRL, pll_word(6, 2, 0, 0, 0));
        rate(5'h14, PER[1]);
        wr(`OFS_PLL_CTRL, pll_word(6, 2, 0, 1, 0));
        rate(5'h14, PER[2]);
        rate(5'h13, PER[0]);
        wr(`OFS_PLL_CTRL, pll_word(6, 2, 0, 1, 1));
        rate(5'h13, PER[2]);
    endtask

    // reset, then every scenario in turn
    initial begin
        // a falling edge is needed to fire the asynchronous reset branches
        reset_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        t_reset();
        t_pll_freq();
        t_src();
        t_presc();
        t_sleep();
        t_net();
        t_pll_mon();
        summarize();
    end
endmodule
